// *** hxt_cfg.svh ***
`ifndef HXT_CFG_SVH
`define HXT_CFG_SVH
// opcode match fields (upper ten or eight bits, or all 16 bits, of 16-bit ops; 32-bit undefined halves), then priority width
`define HXT_TOP10_SIGN_EXTEND_HALF_OP 10'h2C8
`define HXT_TOP10_TEST 10'h108
`define HXT_TOP10_ZXB 10'h2CB
`define HXT_TOP10_ZXH 10'h2CA
`define HXT_UDF_HI8 8'hDE
`define HXT_WAIT_EV 16'hBF20
`define HXT_WAIT_INT 16'hBF30
`define HXT_YIELD 16'hBF10
`define HXT_UDFW_HI12 12'hF7F
`define HXT_UDFW_LO4 4'hA
`define HXT_PRIO_W 8
`endif

// *** hxt_pkg.sv ***
`include "hxt_cfg.svh"
package hxt_pkg;
	typedef enum {HXT_NONE, HXT_TEST, HXT_UDF, HXT_ZXB, HXT_ZXH, HXT_SXH, HXT_WFE, HXT_WFI,
		HXT_YLD} hxt_op_t;
	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} hxt_flags_t;
	typedef struct packed {
		logic valid;
		logic is32;
		logic [15:0] hw0;
		logic [15:0] hw1;
		logic cond_pass;
	} hxt_instr_t;
endpackage : hxt_pkg

// *** hxt_decode.sv ***
`timescale 1ns/1ps
`include "hxt_cfg.svh"
module hxt_decode import hxt_pkg::*; (
	// instruction in
	input wire hxt_instr_t instr,
	// decoded op and register indices
	output hxt_op_t op,
	output logic [2:0] src_idx,
	output logic [2:0] dst_idx
);
	// immediate fields are never looked at, so every value traps alike
	always_comb begin
		op = HXT_NONE;
		src_idx = instr.hw0[5:3];
		dst_idx = instr.hw0[2:0];
		if (instr.is32) begin
			if (instr.hw0[15:4] == `HXT_UDFW_HI12 && instr.hw1[15:12] == `HXT_UDFW_LO4) begin
				op = HXT_UDF; // [RULE_06] [RULE_07]
			end
		end else if (instr.hw0[15:6] == `HXT_TOP10_SIGN_EXTEND_HALF_OP) begin
			op = HXT_SXH; // [RULE_02]
		end else if (instr.hw0[15:6] == `HXT_TOP10_TEST) begin
			op = HXT_TEST; // [RULE_03]
		end else if (instr.hw0[15:6] == `HXT_TOP10_ZXB) begin
			op = HXT_ZXB; // [RULE_08]
		end else if (instr.hw0[15:6] == `HXT_TOP10_ZXH) begin
			op = HXT_ZXH; // [RULE_09]
		end else if (instr.hw0[15:8] == `HXT_UDF_HI8) begin
			op = HXT_UDF; // [RULE_05] [RULE_07]
		end else if (instr.hw0 == `HXT_WAIT_EV) begin
			op = HXT_WFE; // [RULE_10]
		end else if (instr.hw0 == `HXT_WAIT_INT) begin
			op = HXT_WFI; // [RULE_12]
		end else if (instr.hw0 == `HXT_YIELD) begin
			op = HXT_YLD; // [RULE_16]
		end
	end
endmodule : hxt_decode

// *** hxt_exec.sv ***
`timescale 1ns/1ps
`include "hxt_cfg.svh"
// Functional notes
// RULE_01 - sign-extend halfword: source bits 15:0, bit 15 replicated to 32 bits
// RULE_02 - sign-extend halfword decoded from bits 15:6 = 1011001000
// RULE_03 - bit-test decoded from 0100001000; AND of operands, no register write
// RULE_04 - bit-test sets N from bit 31, Z on zero, C kept, V kept
// RULE_05 - 16-bit opcode upper byte 11011110 traps as undefined
// RULE_06 - 32-bit 111101111111/imm4, 1010/imm12 form traps as undefined
// RULE_07 - undefined encodings ignore immediate; all values trap identically
// RULE_08 - byte zero-extend from 1011001011: low 8 bits, upper 24 cleared
// RULE_09 - halfword zero-extend from 1011001010: low 16 bits, upper 16 cleared
// RULE_10 - wait-for-event clears pending event, else sleeps until event
// RULE_11 - wait-for-event suspension ends on any wake event incl. send-event
// RULE_12 - wait-for-interrupt suspends until wake event; raises no exception
// RULE_13 - with mask bit set, higher-priority pending exception still wakes
// RULE_14 - exception at or below execution priority never wakes
// RULE_15 - yield hint marks swappable task; may switch threads
// RULE_16 - yield hint 0xBF10 executes as no-op here
// RULE_17 - failed condition check makes every instruction a no-op
module hxt_exec import hxt_pkg::*; #(
	parameter int PRIO_W = `HXT_PRIO_W
) (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// instruction stream
	input wire hxt_instr_t instr,
	output logic instr_ready,
	// register file read data
	input wire logic [31:0] src_data,
	input wire logic [31:0] dst_data,
	// register file write and read addresses
	output logic rf_we,
	output logic [2:0] rf_waddr,
	output logic [31:0] rf_wdata,
	output logic [2:0] rf_raddr_a,
	output logic [2:0] rf_raddr_b,
	// status flags
	input wire hxt_flags_t flags_in,
	output logic flags_we,
	output hxt_flags_t flags_out,
	// exceptions, lower value means higher priority
	output logic undef_trap,
	input wire logic priority_mask_bit,
	input wire logic irq_pending,
	input wire logic [PRIO_W-1:0] irq_group_prio,
	input wire logic [PRIO_W-1:0] exec_group_prio,
	input wire logic irq_taken,
	// events, sleep and yield hint
	input wire logic event_in,
	input wire logic send_event_any,
	output logic sleeping,
	output logic yield_hint
);
	typedef enum {HXT_RUN, HXT_WAIT_EV_S, HXT_WAIT_INT_S} hxt_state_t;
	hxt_state_t state_q, state_d;
	hxt_op_t op;
	logic [2:0] s_idx, d_idx;
	logic ev_q, ev_d;
	logic we_d, fwe_d, trap_d, yld_d;
	logic sleep_d, rdy_d;
	logic [31:0] wdata_d;
	logic [2:0] waddr_d;
	hxt_flags_t fl_d;
	logic [31:0] and_res;
	logic go, wake_ev, wake_int;

	hxt_decode u_dec (
		.instr(instr),
		.op(op),
		.src_idx(s_idx),
		.dst_idx(d_idx)
	);

	// read ports follow the decoded indices combinationally
	assign rf_raddr_a = s_idx;
	assign rf_raddr_b = d_idx;
	assign and_res = dst_data & src_data; // [RULE_03]
	// a failed condition means nothing is executed at all
	assign go = instr.valid && instr_ready && instr.cond_pass; // [RULE_17]
	assign wake_ev = event_in || send_event_any; // [RULE_11]
	// masked interrupts still wake if they would preempt; equal priority never does
	assign wake_int = wake_ev || (irq_pending && (irq_group_prio < exec_group_prio)
		&& (priority_mask_bit || irq_taken)); // [RULE_13] [RULE_14]

	// next state, event latch and result registers
	always_comb begin
		state_d = state_q;
		ev_d = ev_q || event_in || send_event_any;
		we_d = 1'b0;
		fwe_d = 1'b0;
		trap_d = 1'b0;
		yld_d = 1'b0;
		waddr_d = d_idx;
		wdata_d = 32'h0000_0000;
		fl_d = flags_in;
		case (state_q)
			HXT_RUN: begin
				if (go) begin
					case (op)
						HXT_SXH: begin
							we_d = 1'b1;
							wdata_d = {{16{src_data[15]}}, src_data[15:0]}; // [RULE_01]
						end
						HXT_ZXB: begin
							we_d = 1'b1;
							wdata_d = {24'h00_0000, src_data[7:0]}; // [RULE_08]
						end
						HXT_ZXH: begin
							we_d = 1'b1;
							wdata_d = {16'h0000, src_data[15:0]}; // [RULE_09]
						end
						HXT_TEST: begin
							fwe_d = 1'b1;
							fl_d.n = and_res[31]; // [RULE_04]
							fl_d.z = (and_res == 32'h0000_0000); // [RULE_04]
						end
						HXT_UDF: trap_d = 1'b1; // [RULE_05] [RULE_06]
						HXT_WFE: begin
							// pending event is consumed instead of sleeping
							if (ev_q) begin
								ev_d = event_in || send_event_any; // [RULE_10]
							end else if (!wake_ev) begin
								state_d = HXT_WAIT_EV_S; // [RULE_10]
							end
						end
						HXT_WFI: begin
							if (!wake_int) begin
								state_d = HXT_WAIT_INT_S; // [RULE_12]
							end
						end
						HXT_YLD: yld_d = 1'b1; // [RULE_15] [RULE_16]
						default: ;
					endcase
				end
			end
			HXT_WAIT_EV_S: begin
				if (wake_ev) begin
					state_d = HXT_RUN; // [RULE_11]
					ev_d = 1'b0;
				end
			end
			HXT_WAIT_INT_S: begin
				if (wake_int) begin
					state_d = HXT_RUN; // [RULE_13]
				end
			end
			default: state_d = HXT_RUN;
		endcase
		// status follows the next state so both flip in the same cycle
		sleep_d = (state_d != HXT_RUN);
		rdy_d = (state_d == HXT_RUN);
	end

	// registers only
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q <= HXT_RUN;
			ev_q <= 1'b0;
			rf_we <= 1'b0;
			rf_waddr <= 3'h0;
			rf_wdata <= 32'h0000_0000;
			flags_we <= 1'b0;
			flags_out <= '0;
			undef_trap <= 1'b0;
			yield_hint <= 1'b0;
			sleeping <= 1'b0;
			instr_ready <= 1'b1;
		end else begin
			state_q <= state_d;
			ev_q <= ev_d;
			rf_we <= we_d;
			rf_waddr <= waddr_d;
			rf_wdata <= wdata_d;
			flags_we <= fwe_d;
			flags_out <= fl_d;
			undef_trap <= trap_d;
			yield_hint <= yld_d;
			sleeping <= sleep_d;
			instr_ready <= rdy_d;
		end
	end

	// checks
	a_test_nowrite: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_03]
		go && op == HXT_TEST |=> !rf_we && flags_we) else $error("test wrote reg");
	a_test_flags: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_04]
		go && op == HXT_TEST |=> flags_out.n == $past(and_res[31])
		&& flags_out.z == ($past(and_res) == 32'h0000_0000)
		&& flags_out.c == $past(flags_in.c) && flags_out.v == $past(flags_in.v))
		else $error("test flags wrong");
	a_sxh_value: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_01]
		go && op == HXT_SXH |=> rf_we && rf_wdata[31:16] == {16{$past(src_data[15])}}
		&& rf_wdata[15:0] == $past(src_data[15:0]))
		else $error("sign extend wrong");
	a_zxb_value: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_08]
		go && op == HXT_ZXB |=> rf_wdata[31:8] == 24'h00_0000 && rf_we)
		else $error("byte zero extend wrong");
	a_zxh_value: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_09]
		go && op == HXT_ZXH |=> rf_wdata[31:16] == 16'h0000 && rf_we)
		else $error("half zero extend wrong");
	a_udf_trap: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_05]
		go && op == HXT_UDF |=> undef_trap) else $error("undefined no trap");
	a_cond_fail: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_17]
		instr.valid && !instr.cond_pass && instr_ready |=> !rf_we && !flags_we && !undef_trap)
		else $error("failed cond had effect");
	// judged from the raw inputs, not from the wake term the logic uses
	a_wfi_wake: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_13]
		state_q == HXT_WAIT_INT_S && priority_mask_bit && irq_pending
		&& irq_group_prio < exec_group_prio |=> !sleeping)
		else $error("wfi did not wake");
	a_wfi_stay: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_14]
		state_q == HXT_WAIT_INT_S && !wake_ev && irq_pending
		&& irq_group_prio >= exec_group_prio |=> sleeping)
		else $error("low prio woke wfi");
	a_wfe_wake: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_11]
		state_q == HXT_WAIT_EV_S && send_event_any |=> !sleeping && !ev_q)
		else $error("wfe did not wake");
	a_wfe_consume: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_10]
		go && op == HXT_WFE && ev_q && !event_in && !send_event_any
		|=> !sleeping && !ev_q)
		else $error("wfe did not consume event");
	a_wfi_quiet: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_12]
		go && op == HXT_WFI |=> !undef_trap && !rf_we && !flags_we)
		else $error("wfi had side effect");
	a_yield_nop: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_16]
		go && op == HXT_YLD |=> yield_hint && !rf_we && !flags_we)
		else $error("yield had effect");
	c_wfe_sleep: cover property (@(posedge mclk) disable iff (!resetn)
		state_q == HXT_WAIT_EV_S ##1 state_q == HXT_RUN);
	c_wfi_sleep: cover property (@(posedge mclk) disable iff (!resetn)
		state_q == HXT_WAIT_INT_S ##1 state_q == HXT_RUN);
	c_udf: cover property (@(posedge mclk) disable iff (!resetn) undef_trap);
	c_test: cover property (@(posedge mclk) disable iff (!resetn) flags_we);
endmodule : hxt_exec

// *** hxt_rf_model.sv ***
`timescale 1ns/1ps
// register file beside the executor; reads are combinational like a real file
module hxt_rf_model (
	// clock
	input wire logic mclk,
	// read ports
	input wire logic [2:0] rf_raddr_a,
	input wire logic [2:0] rf_raddr_b,
	output logic [31:0] src_data,
	output logic [31:0] dst_data,
	// write port
	input wire logic rf_we,
	input wire logic [2:0] rf_waddr,
	input wire logic [31:0] rf_wdata
);
	logic [31:0] mem [8];
	// read data follows the address at once
	assign src_data = mem[rf_raddr_a];
	assign dst_data = mem[rf_raddr_b];
	// plain always so the bench may preload the array
	always @(posedge mclk) begin
		if (rf_we)
			mem[rf_waddr] <= rf_wdata;
	end
endmodule : hxt_rf_model

// *** hint_extend_test_decode_tb_top.sv ***
`timescale 1ns/1ps
module hint_extend_test_decode_tb_top import hxt_pkg::*; ;
	logic mclk, resetn, rdy, we, fwe, trap, slp, yh, pmb, irq, tk, ev, send_event_op;
	logic [2:0] wa, ra, rb;
	logic [31:0] wd, sd, dd;
	logic [7:0] ipr, epr;
	hxt_instr_t instr;
	hxt_flags_t fin, fout;
	int err_total = 0;
	int check_count = 0;
	int cyc = 0;
	hxt_exec hxt_exec_inst (.mclk(mclk), .resetn(resetn), .instr(instr), .instr_ready(rdy),
		.src_data(sd), .dst_data(dd), .rf_we(we), .rf_waddr(wa), .rf_wdata(wd),
		.rf_raddr_a(ra), .rf_raddr_b(rb), .flags_in(fin), .flags_we(fwe), .flags_out(fout),
		.undef_trap(trap), .priority_mask_bit(pmb), .irq_pending(irq), .irq_group_prio(ipr),
		.exec_group_prio(epr), .irq_taken(tk), .event_in(ev), .send_event_any(send_event_op),
		.sleeping(slp), .yield_hint(yh));
	hxt_rf_model hxt_rf_model_inst (.mclk(mclk), .rf_raddr_a(ra), .rf_raddr_b(rb),
		.src_data(sd), .dst_data(dd), .rf_we(we), .rf_waddr(wa), .rf_wdata(wd));
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk_word
	task automatic chk_bit(input logic got, input logic exp, input string m);
		chk_word({31'h0, got}, {31'h0, exp}, m);
	endtask : chk_bit
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results
	// one instruction, outputs sampled just after the taken edge
	task automatic issue(input logic [15:0] h0, input logic [15:0] h1, input logic w,
		input logic c);
		@(posedge mclk);
		instr <= '{1'b1, w, h0, h1, c};
		@(posedge mclk);
		instr <= '{1'b0, 1'b0, 16'h0000, 16'h0000, 1'b0};
		#1;
	endtask : issue
	task automatic t_extend();
		logic [15:0] op [3] = '{16'hB20A, 16'hB2CA, 16'hB28A};
		logic [31:0] ex [3] = '{32'hFFFF89AB, 32'h000000AB, 32'h000089AB};
		for (int i = 0; i < 3; i++) begin
			issue(op[i], 16'h0000, 1'b0, 1'b1);
			chk_bit(we, 1'b1, "ext we");
			chk_word({29'h0, wa}, 32'h2, "ext addr");
			chk_word(wd, ex[i], "ext data");
		end
		issue(16'hB2CA, 16'h0000, 1'b0, 1'b0);
		chk_bit(we, 1'b0, "failed cond");
		$display("test extend done");
	endtask : t_extend
	task automatic t_bittest();
		logic [15:0] op [2] = '{16'h4208, 16'h421B};
		logic [3:0] ex [2] = '{4'h7, 4'hB};
		for (int i = 0; i < 2; i++) begin
			issue(op[i], 16'h0000, 1'b0, 1'b1);
			chk_bit(fwe, 1'b1, "test fwe");
			chk_bit(we, 1'b0, "test no write");
			chk_word({28'h0, fout}, {28'h0, ex[i]}, "test flags");
		end
		$display("test bittest done");
	endtask : t_bittest
	task automatic t_undef();
		logic [15:0] a [4] = '{16'hDE00, 16'hDEFF, 16'hF7F0, 16'hF7FF};
		logic [15:0] b [4] = '{16'h0000, 16'h0000, 16'hA000, 16'hAFFF};
		for (int i = 0; i < 4; i++) begin
			issue(a[i], b[i], i > 1, 1'b1);
			chk_bit(trap, 1'b1, "undef trap");
			chk_bit(we, 1'b0, "undef no write");
		end
		$display("test undef done");
	endtask : t_undef
	task automatic t_hints();
		issue(16'hBF10, 16'h0000, 1'b0, 1'b1);
		chk_bit(yh, 1'b1, "yield pulse");
		chk_bit(we | fwe | slp, 1'b0, "yield no-op");
		@(posedge mclk) ev <= 1'b1;
		@(posedge mclk) ev <= 1'b0;
		issue(16'hBF20, 16'h0000, 1'b0, 1'b1);
		chk_bit(slp, 1'b0, "wfe pending");
		issue(16'hBF20, 16'h0000, 1'b0, 1'b1);
		chk_bit(slp, 1'b1, "wfe sleeps");
		@(posedge mclk) send_event_op <= 1'b1;
		@(posedge mclk) send_event_op <= 1'b0;
		#1 chk_bit(slp, 1'b0, "wfe wake");
		issue(16'hBF30, 16'h0000, 1'b0, 1'b1);
		chk_bit(slp | trap, 1'b1, "wfi sleeps");
		chk_bit(trap, 1'b0, "wfi no trap");
		@(posedge mclk) irq <= 1'b1;
		repeat (3) @(posedge mclk);
		#1 chk_bit(slp, 1'b1, "equal prio");
		@(posedge mclk) ipr <= 8'h10;
		@(posedge mclk);
		#1 chk_bit(slp, 1'b0, "higher prio");
		chk_bit(rdy, 1'b1, "ready back");
		@(posedge mclk) irq <= 1'b0;
		$display("test hints done");
	endtask : t_hints
	// time limit on the whole run
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			results();
		end
	end
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial begin
		resetn = 1'b0;
		instr = '{1'b0, 1'b0, 16'h0000, 16'h0000, 1'b0};
		{ev, send_event_op, irq, tk} = 4'h0;
		pmb = 1'b1;
		ipr = 8'h40;
		epr = 8'h40;
		fin = 4'h3;
		hxt_rf_model_inst.mem = '{32'h80000000, 32'h123489AB, 32'h0, 32'hF0000000,
			32'h0, 32'h0, 32'h0, 32'h0};
		repeat (10) @(posedge mclk);
		resetn <= 1'b1;
		t_extend();
		t_bittest();
		t_undef();
		t_hints();
		results();
	end
endmodule : hint_extend_test_decode_tb_top
